// ===== src/fsp_pkg.sv
// package for the flash self-programming sequencer: map, fields, types
package fsp_pkg;

  // ---------------------------------------------------------------
  // flash geometry (word address of the program counter)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W          = 15;
  localparam int unsigned PAGE_W          = 8;
  localparam int unsigned WORD_W          = 7;
  localparam logic [14:0] HALT_REGION_BASE = 15'h7000; // halting region starts here
  // boot section start per boot size setting 0..3
  localparam logic [14:0] BOOT_BASE_0     = 15'h7000;
  localparam logic [14:0] BOOT_BASE_1     = 15'h7800;
  localparam logic [14:0] BOOT_BASE_2     = 15'h7c00;
  localparam logic [14:0] BOOT_BASE_3     = 15'h7e00;

  // ---------------------------------------------------------------
  // control register codes (low seven bits)
  // ---------------------------------------------------------------
  localparam logic [6:0] CMD_PAGE_ERASE  = 7'h03;
  localparam logic [6:0] CMD_BUF_LOAD    = 7'h01;
  localparam logic [6:0] CMD_PAGE_WRITE  = 7'h05;
  localparam logic [6:0] CMD_LOCK_SET    = 7'h09;
  localparam logic [6:0] CMD_REENABLE    = 7'h11;
  localparam int unsigned CTRL_SPMEN     = 0;
  localparam int unsigned CTRL_REENABLE  = 4;
  localparam int unsigned CTRL_BUSY      = 6;
  localparam logic [2:0] ARM_WINDOW      = 3'h4;  // store op must follow within 4 cycles

  // ---------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_LOCK   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ    = 8'h0c;
  localparam logic [7:0] REG_MASK   = 8'h10;
  localparam logic [3:0] LOCK_RESET = 4'hf;  // all lock bits unprogrammed
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_REJECT  = 1;
  localparam int unsigned IRQ_LOCKED  = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned PROG_TIME_US = 4000;
  localparam int unsigned PROG_CYCLES = (PROG_TIME_US * (CLK_HZ / 1_000_000));

  typedef enum logic [1:0] {
    FSP_IDLE  = 2'b00,
    FSP_ERASE = 2'b01,
    FSP_WRITE = 2'b11
  } fsp_state_e;

  // store-program request from the core
  typedef struct packed {
    logic        valid;
    logic [14:0] pc;
    logic [14:0] z;
    logic [15:0] data;
  } fsp_req_s;

  // command to the flash array
  typedef struct packed {
    logic        erase;
    logic        write;
    logic [14:0] page_addr;
  } fsp_flash_s;
endpackage

// ===== src/fsp_ctrl.sv
// flash self-programming sequencer with read-while-write control
//
// Contract
// - store op is rejected when the issuing code sits in the application section
// - store op from boot section may target any page, boot pages included
// - boot size fuses set the boundary between application and boot sections
// - programming the concurrent-read region keeps the core running
// - programming the halting region stalls the core and blocks every flash read
// - boot section always lies inside the halting region
// - busy flag reads one while the concurrent-read region is blocked
// - two independent lock sets, application and boot
// - lock bits set by software or programmer; cleared only by chip erase (reset here also reloads them unprogrammed)
// - general lock modes have no say over self-programming
// - command code written, then store op within four cycles
// - page buffer clears after page write, re-enable write, or reset
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module fsp_ctrl #(
  parameter int unsigned PROG_CYCLES_P = fsp_pkg::PROG_CYCLES
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // core side
  input  wire fsp_pkg::fsp_req_s store_req,
  input  wire logic [1:0]       boot_size_fuses,
  input  wire logic [1:0]       general_lock_mode,
  input  wire logic             chip_erase,
  input  wire logic             prog_lock_wr,
  input  wire logic [3:0]       prog_lock_val,
  output logic                  cpu_halt,
  output logic                  rww_read_block,
  output fsp_pkg::fsp_flash_s   flash_cmd,
  output logic [15:0]           buf_word,
  output logic                  irq
);

  localparam logic [21:0] PROG_CNT = 22'(PROG_CYCLES_P);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    fsp_pkg::fsp_state_e st;
    logic [6:0]          ctrl;
    logic [2:0]          arm;
    logic                busy_flag;
    logic                halt;
    logic [21:0]         cnt;
    logic [3:0]          lock;
    logic [2:0]          irq_stat;
    logic [2:0]          irq_mask;
    logic [127:0]        buf_vld;
    fsp_pkg::fsp_flash_s fcmd;
    logic [31:0]         rdata;
    logic                ack;
    logic                irq;
    logic [15:0]         bword;
  } fsp_regs_s;

  fsp_regs_s q;
  fsp_regs_s d;

  logic [15:0] buf_mem [0:127];

  // boot section start from the boot size fuses
  function automatic logic [14:0] boot_base(input logic [1:0] sz);
    case (sz)
      2'h0:    boot_base = fsp_pkg::BOOT_BASE_0;
      2'h1:    boot_base = fsp_pkg::BOOT_BASE_1;
      2'h2:    boot_base = fsp_pkg::BOOT_BASE_2;
      default: boot_base = fsp_pkg::BOOT_BASE_3;
    endcase
  endfunction

  // locked means lock bit pair not both unprogrammed (one blocks self-writes)
  function automatic logic sect_locked(input logic [1:0] lk);
    sect_locked = (lk != 2'h3);
  endfunction

  logic        wb_req;
  logic        in_boot;
  logic        tgt_boot;
  logic        tgt_halt;
  logic        locked;
  logic [6:0]  widx;
  logic [2:0]  irq_w1c;
  logic [2:0]  irq_evt;
  logic        buf_clr;
  logic        buf_wr;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d        = q;
    wb_req   = wb_cyc_i && wb_stb_i && !q.ack;
    in_boot  = store_req.pc >= boot_base(boot_size_fuses);
    tgt_boot = store_req.z >= boot_base(boot_size_fuses);
    // fuse table keeps every boot base at or above the fixed halting base
    tgt_halt = store_req.z >= fsp_pkg::HALT_REGION_BASE;
    // general_lock_mode deliberately unused here
    locked   = tgt_boot ? sect_locked(q.lock[3:2])
                        : sect_locked(q.lock[1:0]);
    widx     = store_req.z[fsp_pkg::WORD_W-1:0];
    irq_w1c  = 3'h0;
    irq_evt  = 3'h0;
    buf_clr  = 1'b0;
    buf_wr   = 1'b0;
    d.ack    = wb_req;
    d.fcmd.erase = 1'b0;
    d.fcmd.write = 1'b0;
    if (q.arm != 3'h0) begin
      d.arm = q.arm - 3'h1;
    end

    // -------------------------------------------------------------
    // bus writes
    // -------------------------------------------------------------
    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        fsp_pkg::REG_CTRL: begin
          if (q.st == fsp_pkg::FSP_IDLE) begin
            d.ctrl = wb_dat_i[6:0];
            d.arm  = fsp_pkg::ARM_WINDOW;
          end
        end
        fsp_pkg::REG_IRQ:  irq_w1c = wb_dat_i[2:0];
        fsp_pkg::REG_MASK: d.irq_mask = wb_dat_i[2:0];
        default: ;
      endcase
    end

    // -------------------------------------------------------------
    // store operation from the core
    // -------------------------------------------------------------
    if (store_req.valid && q.st == fsp_pkg::FSP_IDLE && q.arm != 3'h0) begin
      d.arm  = 3'h0;
      d.ctrl = 7'h00;
      if (!in_boot) begin
        irq_evt[fsp_pkg::IRQ_REJECT] = 1'b1;
      end else begin
        case (q.ctrl)
          fsp_pkg::CMD_BUF_LOAD: begin
            buf_wr = !q.buf_vld[widx];
            d.buf_vld[widx] = 1'b1;
          end
          fsp_pkg::CMD_PAGE_ERASE, fsp_pkg::CMD_PAGE_WRITE: begin
            if (locked) begin
              irq_evt[fsp_pkg::IRQ_LOCKED] = 1'b1;
            end else begin
              // any page reachable, boot pages too
              d.fcmd.page_addr = store_req.z;
              d.fcmd.erase = (q.ctrl == fsp_pkg::CMD_PAGE_ERASE);
              d.fcmd.write = (q.ctrl == fsp_pkg::CMD_PAGE_WRITE);
              d.st   = (q.ctrl == fsp_pkg::CMD_PAGE_ERASE) ? fsp_pkg::FSP_ERASE
                                                           : fsp_pkg::FSP_WRITE;
              d.cnt  = PROG_CNT;
              d.busy_flag = 1'b1;
              d.halt = tgt_halt;
            end
          end
          fsp_pkg::CMD_LOCK_SET: d.lock = q.lock & store_req.data[5:2];
          fsp_pkg::CMD_REENABLE: begin
            if (!q.busy_flag || q.st == fsp_pkg::FSP_IDLE) begin
              d.busy_flag = 1'b0;
            end
            buf_clr = 1'b1;
          end
          default: ;
        endcase
      end
    end

    // -------------------------------------------------------------
    // programming timer
    // -------------------------------------------------------------
    case (q.st)
      fsp_pkg::FSP_IDLE: ;
      fsp_pkg::FSP_ERASE, fsp_pkg::FSP_WRITE: begin
        if (q.cnt <= 22'h1) begin
          d.st   = fsp_pkg::FSP_IDLE;
          d.halt = 1'b0;
          irq_evt[fsp_pkg::IRQ_DONE] = 1'b1;
          buf_clr = (q.st == fsp_pkg::FSP_WRITE);
        end else begin
          d.cnt = q.cnt - 22'h1;
        end
      end
      default: d.st = fsp_pkg::FSP_IDLE;
    endcase

    // -------------------------------------------------------------
    // programmer path: lock bits set by programmer, cleared by chip erase or by reset
    // -------------------------------------------------------------
    if (prog_lock_wr) begin
      d.lock = d.lock & prog_lock_val;
    end
    if (chip_erase) begin
      d.lock = fsp_pkg::LOCK_RESET;
    end
    if (buf_clr) begin
      d.buf_vld = '0;
    end

    // -------------------------------------------------------------
    // interrupt status
    // -------------------------------------------------------------
    // write-one-to-clear; a new event in the same cycle wins, even on a set bit,
    // so software never loses an event that races its own clear
    d.irq_stat = (q.irq_stat & ~irq_w1c) | irq_evt;
    d.irq   = |(d.irq_stat & d.irq_mask);
    d.bword = buf_wr ? store_req.data : q.bword;

    // -------------------------------------------------------------
    // read mux
    // -------------------------------------------------------------
    d.rdata = 32'h0;
    case (wb_adr_i)
      fsp_pkg::REG_CTRL:   d.rdata = {25'h0, q.busy_flag, q.ctrl[5:0]};
      fsp_pkg::REG_LOCK:   d.rdata = {28'h0, q.lock};
      fsp_pkg::REG_STATUS: d.rdata = {29'h0, q.halt, q.st};
      fsp_pkg::REG_IRQ:    d.rdata = {29'h0, q.irq_stat};
      fsp_pkg::REG_MASK:   d.rdata = {29'h0, q.irq_mask};
      default:             d.rdata = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q          <= '0;
      q.st       <= fsp_pkg::FSP_IDLE;
      q.lock     <= fsp_pkg::LOCK_RESET;
    end else begin
      q <= d;
    end
  end

  // page buffer storage; valid bits above gate rewrites
  always_ff @(posedge clk_sys) begin
    if (buf_wr) begin
      buf_mem[widx] <= store_req.data;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_dat_o       = q.rdata;
  assign wb_ack_o       = q.ack;
  assign cpu_halt       = q.halt;
  assign rww_read_block = q.busy_flag;
  assign flash_cmd      = q.fcmd;
  assign buf_word       = q.bword;
  assign irq            = q.irq;

endmodule

// ===== tb/fsp_ctrl_asserts.sv
// concurrent checks on the ports of the flash self-programming sequencer
`timescale 1ns/1ps
module fsp_ctrl_asserts #(
  parameter int unsigned PROG_CYCLES_P = 8
) (
  input wire logic                clk_sys,
  input wire logic                reset,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire fsp_pkg::fsp_req_s   store_req,
  input wire logic                cpu_halt,
  input wire logic                rww_read_block,
  input wire fsp_pkg::fsp_flash_s flash_cmd
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  int unsigned hcnt_q;
  // cycles the core has been halted so far
  always_ff @(posedge clk_sys) begin
    hcnt_q <= (reset || !cpu_halt) ? 0 : hcnt_q + 1;
  end
  sequence s_halt_op;
    (flash_cmd.erase || flash_cmd.write) && flash_cmd.page_addr >= fsp_pkg::HALT_REGION_BASE;
  endsequence
  sequence s_rww_op;
    (flash_cmd.erase || flash_cmd.write) && flash_cmd.page_addr < fsp_pkg::HALT_REGION_BASE;
  endsequence
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acked");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_app_reject: assert property (
    store_req.valid && store_req.pc < fsp_pkg::HALT_REGION_BASE
    |=> !(flash_cmd.erase || flash_cmd.write)) else $error("application store op ran");
  a_rww_runs: assert property (s_rww_op |-> (!cpu_halt)[*8])
    else $error("core halted on concurrent region op");
  a_halt_holds: assert property (s_halt_op |-> cpu_halt[*8])
    else $error("halt dropped early");
  a_halt_bound: assert property (hcnt_q <= PROG_CYCLES_P)
    else $error("halt too long");
  a_halt_blocks: assert property (cpu_halt |-> rww_read_block)
    else $error("halt without busy flag");
  a_busy_sticky: assert property (
    rww_read_block && !store_req.valid |=> rww_read_block) else $error("busy flag lost");
  a_busy_start: assert property (s_rww_op |-> rww_read_block)
    else $error("busy flag not raised");
endmodule

bind fsp_ctrl fsp_ctrl_asserts #(.PROG_CYCLES_P(PROG_CYCLES_P)) i_fsp_ctrl_asserts (
  .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .store_req(store_req), .cpu_halt(cpu_halt),
  .rww_read_block(rww_read_block), .flash_cmd(flash_cmd));

// ===== tb/fsp_core_model.sv
// core model issuing store-program operations from a caller-given program counter
`timescale 1ns/1ps
module fsp_core_model (
  input  wire logic         clk_sys,
  output fsp_pkg::fsp_req_s store_req
);
  initial store_req = '0;
  // code address comes from the caller; tests issue from both application and boot sections
  task automatic issue(input logic [14:0] p, z, input logic [15:0] d);
    @(posedge clk_sys);
    store_req <= '{1'b1, p, z, d};
    @(posedge clk_sys);
    store_req <= '{1'b0, ~p, ~z, ~d}; // released lines keep no stale value
  endtask
endmodule

// ===== tb/fsp_ctrl_tb.sv
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module fsp_ctrl_tb;
  logic                clk_sys = 1'b0;
  logic                reset = 1'b1;
  logic                cyc = 0, we = 0, chip_erase = 0, plw = 0, ack, halt, busy, irq;
  logic [7:0]          adr = '0;
  logic [31:0]         dat = '0, rdat, rq;
  logic [3:0]          sel = '0, lval = '0;
  logic [1:0]          fuses = 2'h3, glock = '0;
  logic [15:0]         bw;
  int                  num_errors = 0, compares = 0;
  fsp_pkg::fsp_req_s   req;
  fsp_pkg::fsp_flash_s fc;

  always #12.5 clk_sys = ~clk_sys;

  fsp_ctrl #(.PROG_CYCLES_P(8)) i_fsp_ctrl (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .store_req(req), .boot_size_fuses(fuses), .general_lock_mode(glock),
    .chip_erase(chip_erase), .prog_lock_wr(plw), .prog_lock_val(lval), .cpu_halt(halt),
    .rww_read_block(busy), .flash_cmd(fc), .buf_word(bw), .irq(irq));
  fsp_core_model i_fsp_core_model (.clk_sys(clk_sys), .store_req(req));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // classic cycle; cyc doubles as stb since both rise and fall together
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h1;
    // no cycle count assumed; a hung slave is ended by the watchdog
    do @(posedge clk_sys); while (ack !== 1'b1);
    rq = rdat;
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rq, e);
  endtask
  task automatic op(input logic [6:0] c, input logic [14:0] p, z, input logic [15:0] d);
    wb(1'b1, fsp_pkg::REG_CTRL, {25'h0, c});
    i_fsp_core_model.issue(p, z, d);
    @(negedge clk_sys);
  endtask
  task automatic end_sim();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(fsp_pkg::REG_LOCK, 32'hf);
    rd(fsp_pkg::REG_CTRL, 32'h0);
    rd(fsp_pkg::REG_STATUS, 32'h0);
    wb(1'b1, 8'h20, 32'hff);
    rd(8'h20, 32'h0);
    $display("regs done");
  endtask
  task automatic t_reject();
    wb(1'b1, fsp_pkg::REG_MASK, 32'h7);
    rd(fsp_pkg::REG_MASK, 32'h7);
    op(fsp_pkg::CMD_PAGE_WRITE, 15'h0100, 15'h0200, 16'h0);
    chk(32'(fc.write), 32'h0);
    rd(fsp_pkg::REG_IRQ, 32'h2);
    chk(32'(irq), 32'h1);
    wb(1'b1, fsp_pkg::REG_MASK, 32'h0);
    repeat (2) @(negedge clk_sys);
    chk(32'(irq), 32'h0);
    wb(1'b1, fsp_pkg::REG_IRQ, 32'h2);
    rd(fsp_pkg::REG_IRQ, 32'h0);
    $display("reject done");
  endtask
  task automatic t_rww();
    op(fsp_pkg::CMD_BUF_LOAD, 15'h7e00, 15'h0005, 16'habcd);
    chk(32'(bw), 32'habcd);
    op(fsp_pkg::CMD_BUF_LOAD, 15'h7e00, 15'h0005, 16'h1234);
    chk(32'(bw), 32'habcd);
    op(fsp_pkg::CMD_PAGE_WRITE, 15'h7e00, 15'h0105, 16'h0);
    chk(32'(fc), {15'h0, 2'b01, 15'h0105});
    chk(32'({halt, busy}), 32'h1);
    repeat (10) @(negedge clk_sys);
    rd(fsp_pkg::REG_CTRL, 32'h40);
    rd(fsp_pkg::REG_IRQ, 32'h1);
    op(fsp_pkg::CMD_BUF_LOAD, 15'h7e00, 15'h0005, 16'h1234);
    chk(32'(bw), 32'h1234);
    op(fsp_pkg::CMD_REENABLE, 15'h7e00, 15'h0, 16'h0);
    chk(32'(busy), 32'h0);
    $display("rww done");
  endtask
  task automatic t_fuses();
    logic [14:0] bb [4];
    bb = '{fsp_pkg::BOOT_BASE_0, fsp_pkg::BOOT_BASE_1, fsp_pkg::BOOT_BASE_2,
           fsp_pkg::BOOT_BASE_3};
    for (int f = 0; f < 4; f++) begin
      @(posedge clk_sys);
      fuses <= f[1:0];
      glock <= f[1:0];
      op(fsp_pkg::CMD_PAGE_ERASE, bb[f] - 15'h1, 15'h7e40, 16'h0);
      chk(32'(fc.erase), 32'h0);
      op(fsp_pkg::CMD_PAGE_ERASE, bb[f], 15'h7e40, 16'h0);
      chk(32'({fc.erase, halt}), 32'h3);
      rd(fsp_pkg::REG_STATUS, 32'h5);
      repeat (10) @(negedge clk_sys);
    end
    $display("fuses done");
  endtask
  task automatic t_lock();
    op(fsp_pkg::CMD_LOCK_SET, 15'h7e00, 15'h0, 16'h0030);
    wb(1'b1, fsp_pkg::REG_IRQ, 32'h7);
    rd(fsp_pkg::REG_LOCK, 32'hc);
    wb(1'b1, fsp_pkg::REG_LOCK, 32'hf);
    rd(fsp_pkg::REG_LOCK, 32'hc);
    op(fsp_pkg::CMD_PAGE_WRITE, 15'h7e00, 15'h0100, 16'h0);
    chk(32'(fc.write), 32'h0);
    rd(fsp_pkg::REG_IRQ, 32'h4);
    op(fsp_pkg::CMD_PAGE_WRITE, 15'h7e00, 15'h7e40, 16'h0);
    chk(32'(fc.write), 32'h1);
    repeat (10) @(negedge clk_sys);
    @(posedge clk_sys);
    plw <= 1'b1;
    lval <= 4'h3;
    @(posedge clk_sys);
    plw <= 1'b0;
    rd(fsp_pkg::REG_LOCK, 32'h0);
    @(posedge clk_sys);
    chip_erase <= 1'b1;
    @(posedge clk_sys);
    chip_erase <= 1'b0;
    rd(fsp_pkg::REG_LOCK, 32'hf);
    $display("lock done");
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_reject();
    t_rww();
    t_fuses();
    t_lock();
    end_sim();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #125000;
    num_errors++;
    end_sim();
  end
endmodule
